// ---- hdl/swm_pkg.sv ----
// shared constants and types for the selective wake mode controller
package swm_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int CTL_CFG = 8;
	localparam int CTL_ECLR = 9;
	localparam int ST_ERR = 6;
	localparam int ST_ARM = 7;
	localparam int ST_SIL = 8;
	localparam int ST_CFG = 9;
	localparam int ST_SWA = 15;
	localparam logic [2:0] MODE_OFF0 = 3'h0;
	localparam logic [2:0] MODE_WAKE = 3'h1;
	localparam logic [2:0] MODE_NORM = 3'h3;
	localparam logic [2:0] MODE_OFF1 = 3'h4;
	localparam logic [2:0] MODE_SW = 3'h5;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [1:0] PREQ_NORMAL = 2'h0;
	localparam logic [1:0] PREQ_STOP = 2'h1;
	localparam logic [1:0] PREQ_SLEEP = 2'h2;
	localparam int CNT_W = 6;
	localparam logic [5:0] CNT_OVF_AT = 6'h1f;
	localparam logic [5:0] CNT_RST = 6'h00;
	typedef enum logic [1:0] {PWR_NORMAL, PWR_STOP, PWR_SLEEP, PWR_RESTART} swm_pwr_t;
	typedef enum logic [1:0] {OP_OFF, OP_WAKE, OP_RXO, OP_NORM} swm_op_t;
	typedef enum logic [2:0] {CS_IDLE, CS_FRAME, CS_PAT1, CS_PAT2, CS_WOKEN} swm_cs_t;
endpackage

// ---- hdl/swm_err_cnt.sv ----
// frame error counter, saturating one above the overflow point
`timescale 1ns/100ps
module swm_err_cnt #(
	parameter int W = swm_pkg::CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic frz,
	input wire logic clr,
	input wire logic inc,
	input wire logic dec,
	output logic [W-1:0] count,
	output logic ovf
);
	logic live;
	// frozen while woken so software can read the value that woke it
	assign live = en && !frz;
	assign ovf = live && inc && (count == W'(swm_pkg::CNT_OVF_AT));

	// count update, clear wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= W'(swm_pkg::CNT_RST);
		else if (clr)
			count <= W'(swm_pkg::CNT_RST);
		else if (live && inc && count <= W'(swm_pkg::CNT_OVF_AT))
			count <= count + W'(1);
		else if (live && dec && !inc && count != '0)
			count <= count - W'(1);
	end
endmodule

// ---- hdl/swm_xlat.sv ----
// can mode translation for a given power mode
`timescale 1ns/100ps
module swm_xlat (
	input wire swm_pkg::swm_pwr_t pwr,
	input wire logic [2:0] field,
	input wire logic err,
	output swm_pkg::swm_op_t op,
	output logic sw_en,
	output logic [2:0] field_out
);
	logic off;
	logic sw_req;
	assign off = (field[1:0] == 2'h0);
	assign sw_req = field[2] && !off;

	// low bits pick the base mode, msb asks for selective wake
	always_comb
	begin
		op = swm_pkg::swm_op_t'(field[1:0]);
		sw_en = sw_req && !err;
		field_out = field;
		unique case (pwr)
			swm_pkg::PWR_NORMAL:
				op = swm_pkg::swm_op_t'(field[1:0]);
			swm_pkg::PWR_STOP:
			begin
				if (field == swm_pkg::MODE_NORM)
					op = swm_pkg::OP_WAKE;
			end
			swm_pkg::PWR_SLEEP:
			begin
				op = off ? swm_pkg::OP_OFF : swm_pkg::OP_WAKE;
				if (!off)
					field_out = field[2] ? swm_pkg::MODE_SW : swm_pkg::MODE_WAKE;
			end
			swm_pkg::PWR_RESTART:
			begin
				op = off ? swm_pkg::OP_OFF : swm_pkg::OP_WAKE;
				sw_en = 1'b0;
			end
		endcase
	end
endmodule

// ---- hdl/swm_ctrl.sv ----
// selective wake can mode controller with apb register access
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
module swm_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic silence_tick,
	input wire logic wake_pattern,
	input wire logic wake_frame,
	input wire logic frame_err,
	input wire logic frame_ok,
	input wire logic config_err,
	output logic tx_enable,
	output logic rx_enable,
	output logic rxd_force_low,
	output logic selwake_active,
	output logic can_wake_irq,
	output logic selwake_armed_flag,
	output logic selwake_error_flag,
	output logic bus_silence_flag
);
	swm_pkg::swm_pwr_t pwr_r, pwr_nxt;
	swm_pkg::swm_op_t op_r, op_nxt;
	swm_pkg::swm_cs_t cs_r, cs_nxt, cs_tgt;
	logic [2:0] field_r, field_wr, field_nxt;
	logic err_r, err_nxt, cfg_r, cfg_nxt;
	logic armed_r, armed_nxt, sil_r, sw_en_r, sw_en_nxt;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic tx_r, rx_r, rxlow_r, irq_r;
	logic wr, wr_ctrl, fld_wr_ok, rearm, wake_ev, frame_wake, ovf;
	logic ent_sleep, ent_restart, err_set, err_clr, cnt_en, cnt_clr, sw_code;
	logic [1:0] preq;
	logic [5:0] cnt;

	// a register access completes at the edge where pready is seen
	assign wr = psel && penable && pwrite && pready_r;
	assign wr_ctrl = wr && (paddr == swm_pkg::REG_CTRL);
	assign preq = pwdata[5:4];

	// apb handshake: one-cycle ready in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable &&
				!(paddr == swm_pkg::REG_CTRL || (paddr == swm_pkg::REG_STAT && !pwrite));
		end
	end

	// read data captured in setup; unmapped reads give zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			prdata_r <= 32'h0;
			if (paddr == swm_pkg::REG_CTRL)
			begin
				prdata_r[2:0] <= field_r;
				prdata_r[5:4] <= 2'(pwr_r);
				prdata_r[swm_pkg::CTL_CFG] <= cfg_r;
			end
			else if (paddr == swm_pkg::REG_STAT)
			begin
				prdata_r[2:0] <= field_r;
				prdata_r[5:4] <= 2'(pwr_r);
				prdata_r[swm_pkg::ST_ERR] <= err_r;
				prdata_r[swm_pkg::ST_ARM] <= armed_r;
				prdata_r[swm_pkg::ST_SIL] <= sil_r;
				prdata_r[swm_pkg::ST_CFG] <= cfg_r;
				prdata_r[12:10] <= 3'(cs_r);
				prdata_r[14:13] <= 2'(op_r);
				prdata_r[swm_pkg::ST_SWA] <= sw_en_r;
				prdata_r[21:16] <= cnt;
			end
		end
	end

	// wake sources depend on the detection state the can block sits in
	assign frame_wake = (cs_r == swm_pkg::CS_FRAME) && wake_frame;
	assign wake_ev = frame_wake || ovf ||
		((cs_r == swm_pkg::CS_PAT2) && wake_pattern);

	// power mode requests; only a wake leaves sleep
	always_comb
	begin
		pwr_nxt = pwr_r;
		if (pwr_r == swm_pkg::PWR_SLEEP)
		begin
			if (wake_ev)
				pwr_nxt = swm_pkg::PWR_RESTART;
		end
		else if (wr_ctrl && preq == swm_pkg::PREQ_NORMAL)
			pwr_nxt = swm_pkg::PWR_NORMAL;
		else if (wr_ctrl && pwr_r == swm_pkg::PWR_NORMAL && preq == swm_pkg::PREQ_STOP)
			pwr_nxt = swm_pkg::PWR_STOP;
		else if (wr_ctrl && pwr_r == swm_pkg::PWR_NORMAL && preq == swm_pkg::PREQ_SLEEP)
			pwr_nxt = swm_pkg::PWR_SLEEP;
	end
	assign ent_sleep = (pwr_nxt == swm_pkg::PWR_SLEEP) && (pwr_r != swm_pkg::PWR_SLEEP);
	assign ent_restart = (pwr_nxt == swm_pkg::PWR_RESTART) && (pwr_r != swm_pkg::PWR_RESTART);

	// software changes the field only in normal mode; sleep entry also rewrites it through the translation
	assign fld_wr_ok = wr_ctrl && (pwr_r == swm_pkg::PWR_NORMAL);
	assign field_wr = fld_wr_ok ? pwdata[2:0] : field_r;
	// a changed mode write leaves the woken state; sleep entry too
	assign rearm = (fld_wr_ok && pwdata[2:0] != field_r) || ent_sleep;

	// translation runs on next values so it lands with the power change
	swm_xlat u_xlat (
		.pwr(pwr_nxt),
		.field(field_wr),
		.err(err_nxt),
		.op(op_nxt),
		.sw_en(sw_en_nxt),
		.field_out(field_nxt)
	);

	// error flag: set wins over software clear; off code 100 never sets it
	assign sw_code = field_wr[2] && (field_wr[1:0] != 2'h0);
	// config check sees the cfg bit of the same write, so one write can arm
	assign err_set = sw_code && (config_err || ovf ||
		(fld_wr_ok && pwdata[2:0] != field_r && !cfg_nxt) ||
		(ent_restart && !frame_wake));
	// cannot be cleared while a selective wake code lacks valid config
	assign err_clr = wr_ctrl && pwdata[swm_pkg::CTL_ECLR] && !(field_wr[2] && !cfg_nxt);
	assign err_nxt = err_set || (err_r && !err_clr);

	// config valid: software write wins over the restart clear
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (wr_ctrl)
			cfg_nxt = pwdata[swm_pkg::CTL_CFG];
		else if (ent_restart)
			cfg_nxt = 1'b0;
	end

	// where an unwoken transceiver lands for the current settings
	always_comb
	begin
		if (sw_en_nxt)
			cs_tgt = swm_pkg::CS_FRAME;
		else if (op_nxt == swm_pkg::OP_WAKE)
			cs_tgt = swm_pkg::CS_PAT2;
		else
			cs_tgt = swm_pkg::CS_IDLE;
	end

	// can detection state; woken holds until re-armed
	always_comb
	begin
		cs_nxt = cs_tgt;
		unique case (cs_r)
			swm_pkg::CS_WOKEN:
				cs_nxt = rearm ? cs_tgt : swm_pkg::CS_WOKEN;
			swm_pkg::CS_FRAME:
			begin
				if (wake_ev)
					cs_nxt = swm_pkg::CS_WOKEN;
				else if (sw_en_nxt && silence_tick)
					cs_nxt = swm_pkg::CS_PAT1;
			end
			swm_pkg::CS_PAT1:
			begin
				if (wake_ev)
					cs_nxt = swm_pkg::CS_WOKEN;
				else if (sw_en_nxt && !wake_pattern)
					cs_nxt = swm_pkg::CS_PAT1;
			end
			swm_pkg::CS_IDLE, swm_pkg::CS_PAT2:
			begin
				if (wake_ev)
					cs_nxt = swm_pkg::CS_WOKEN;
			end
		endcase
	end

	// armed follows the next state, so a wake or msb write drops it
	assign armed_nxt = (sw_en_nxt && (cs_nxt == swm_pkg::CS_FRAME ||
		cs_nxt == swm_pkg::CS_PAT1)) ||
		(err_nxt && field_nxt[2] && cs_nxt == swm_pkg::CS_PAT2);

	// counter runs in normal, rx only and frame detection
	assign cnt_en = (op_r == swm_pkg::OP_NORM) || (op_r == swm_pkg::OP_RXO) ||
		(cs_r == swm_pkg::CS_FRAME);
	assign cnt_clr = (cs_r == swm_pkg::CS_FRAME && cs_nxt == swm_pkg::CS_PAT1) ||
		(cs_r != swm_pkg::CS_FRAME && cs_nxt == swm_pkg::CS_FRAME) ||
		(cs_r == swm_pkg::CS_WOKEN && cs_nxt != swm_pkg::CS_WOKEN) ||
		field_r == swm_pkg::MODE_OFF0 || field_r == swm_pkg::MODE_OFF1 ||
		field_r == swm_pkg::MODE_WAKE;

	swm_err_cnt #(
		.W(swm_pkg::CNT_W)
	) u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.en(cnt_en),
		.frz(cs_r == swm_pkg::CS_WOKEN),
		.clr(cnt_clr),
		.inc(frame_err),
		.dec(frame_ok),
		.count(cnt),
		.ovf(ovf)
	);

	// mode and flag state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_r <= swm_pkg::PWR_NORMAL;
			field_r <= swm_pkg::MODE_RST;
			op_r <= swm_pkg::OP_OFF;
			cs_r <= swm_pkg::CS_IDLE;
			err_r <= 1'b0;
			cfg_r <= 1'b0;
			armed_r <= 1'b0;
			sw_en_r <= 1'b0;
		end
		else
		begin
			pwr_r <= pwr_nxt;
			field_r <= field_nxt;
			op_r <= op_nxt;
			cs_r <= cs_nxt;
			err_r <= err_nxt;
			cfg_r <= cfg_nxt;
			armed_r <= armed_nxt;
			sw_en_r <= sw_en_nxt;
		end
	end

	// silence flag: set wins over the pattern clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sil_r <= 1'b0;
		else if (silence_tick && (cs_r == swm_pkg::CS_FRAME || cs_r == swm_pkg::CS_PAT2))
			sil_r <= 1'b1;
		else if (wake_pattern)
			sil_r <= 1'b0;
	end

	// transceiver controls, registered from next values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_r <= 1'b0;
			rx_r <= 1'b0;
			rxlow_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			tx_r <= (op_nxt == swm_pkg::OP_NORM);
			rx_r <= (op_nxt == swm_pkg::OP_NORM) || (op_nxt == swm_pkg::OP_RXO);
			// an active receiver keeps real bus data on rxd
			rxlow_r <= (cs_nxt == swm_pkg::CS_WOKEN) && (op_nxt == swm_pkg::OP_WAKE ||
				op_nxt == swm_pkg::OP_OFF);
			irq_r <= wake_ev && (pwr_r != swm_pkg::PWR_SLEEP);
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_enable = tx_r;
	assign rx_enable = rx_r;
	assign rxd_force_low = rxlow_r;
	assign selwake_active = sw_en_r;
	assign can_wake_irq = irq_r;
	assign selwake_armed_flag = armed_r;
	assign selwake_error_flag = err_r;
	assign bus_silence_flag = sil_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence stop_hold_s;
		pwr_r == swm_pkg::PWR_STOP ##1 pwr_r == swm_pkg::PWR_STOP;
	endsequence
	sequence enter_sleep_s;
		pwr_r != swm_pkg::PWR_SLEEP ##1 pwr_r == swm_pkg::PWR_SLEEP;
	endsequence

	arm_on_enable_a: assert property (
		(sw_en_r && cs_r == swm_pkg::CS_FRAME) |-> armed_r)
		else $error("armed flag missing in frame detection");
	arm_after_err_a: assert property (
		(err_r && field_r[2] && cs_r == swm_pkg::CS_PAT2) |-> armed_r)
		else $error("armed flag missing after error");
	wake_clears_arm_a: assert property (
		wake_ev |=> !armed_r && cs_r == swm_pkg::CS_WOKEN)
		else $error("wake did not clear armed flag");
	msb_clears_arm_a: assert property (
		(fld_wr_ok && !pwdata[2]) |=> !armed_r)
		else $error("msb zero write left armed flag");
	field_locked_a: assert property (
		stop_hold_s |-> $stable(field_r))
		else $error("mode field changed in stop");
	rxo_no_tx_a: assert property (
		op_r == swm_pkg::OP_RXO |-> !tx_enable && rx_enable)
		else $error("rx only mode drives bus");
	irq_no_rxlow_a: assert property (
		(can_wake_irq && op_r == swm_pkg::OP_NORM) |-> !rxd_force_low)
		else $error("rxd forced low in normal mode");
	err_means_off_a: assert property (
		sw_en_r |-> !err_r)
		else $error("selective wake active with error flag");
	sleep_rewrite_a: assert property (
		enter_sleep_s |-> field_r inside {3'h0, 3'h1, 3'h4, 3'h5})
		else $error("sleep field not rewritten");
	stop_keeps_a: assert property (
		pwr_r == swm_pkg::PWR_NORMAL ##1 pwr_r == swm_pkg::PWR_STOP |->
			field_r == $past(field_wr))
		else $error("stop entry changed field");
endmodule

// ---- tb/swm_can_node.sv ----
// behavioural can bus node that turns a request into one event pulse
`timescale 1ns/100ps
module swm_can_node (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fire,
	input wire logic [2:0] kind,
	output logic [5:0] ev
);
	// one cycle per event; the lines fall back low between requests
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev <= 6'h00;
		else
			ev <= fire ? 6'(6'h01 << kind) : 6'h00;
	end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the selective wake can mode controller
`timescale 1ns/100ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic fire = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, x;
	logic [5:0] ev;
	logic pready, pslverr, err, tx_enable, rx_enable, rxd_force_low, selwake_active;
	logic can_wake_irq, selwake_armed_flag, selwake_error_flag, bus_silence_flag;
	int bad_count = 0;
	int checks_done = 0;
	int irq_seen = 0;
	int n;

	// 50 MHz bus clock
	always #10 pclk = ~pclk;

	swm_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .silence_tick(ev[0]), .wake_pattern(ev[1]), .wake_frame(ev[2]),
		.frame_err(ev[3]), .frame_ok(ev[4]), .config_err(ev[5]), .tx_enable, .rx_enable,
		.rxd_force_low, .selwake_active, .can_wake_irq, .selwake_armed_flag,
		.selwake_error_flag, .bus_silence_flag);
	swm_can_node node (.pclk, .presetn, .fire, .kind, .ev);

	// count wake interrupt pulses, each is one cycle wide
	always @(posedge pclk)
	begin
		if (can_wake_irq === 1'b1)
			irq_seen <= irq_seen + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(k), 32'h1, "wait states");
	endtask

	task automatic wr(input logic [2:0] c, input logic cfg, input logic [1:0] p, input logic ec);
		apb(1'b1, swm_pkg::REG_CTRL, {22'h0, ec, cfg, 2'h0, p, 1'b0, c});
	endtask

	task automatic send(input logic [2:0] k);
		@(posedge pclk);
		fire <= 1'b1;
		kind <= k;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// can state, cfg, silence and armed bits against status and pins
	task automatic stw(input logic [5:0] s);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(32'(rd[12:7]), 32'(s), "state");
		chk(32'({selwake_armed_flag, bus_silence_flag}), 32'({s[0], s[1]}), "flag pins");
	endtask

	// field, power, error, op and selective wake status plus the mode pins
	task automatic look();
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h0000e077, x, "mode");
		chk(32'({tx_enable, rx_enable, selwake_active}), 32'({&x[14:13], x[14], x[15]}), "pins");
	endtask

	// status expected after a power change; low bits give the op in normal
	function automatic logic [31:0] expect_stat(input logic [2:0] c, input logic [1:0] p,
		input logic e);
		logic [2:0] f;
		logic [1:0] o;
		f = c;
		o = c[1:0];
		if (p == swm_pkg::PREQ_STOP && c == 3'h3)
			o = 2'h1;
		if (p == swm_pkg::PREQ_SLEEP && c[1:0] != 2'h0)
		begin
			o = 2'h1;
			f = c[2] ? 3'h5 : 3'h1;
		end
		return {16'h0, c[2] && c[1:0] != 2'h0 && !e, o, 6'h0, e, p, 1'b0, f};
	endfunction

	// a hang ends the run well past its expected length
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(11038));
		do_reset();
		apb(1'b0, swm_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(err), 32'h1, "unmapped");
		apb(1'b1, swm_pkg::REG_STAT, 32'h0000ffff);
		chk(32'(err), 32'h1, "stat write");
		// every code, with valid and invalid config, into stop and sleep
		for (int e = 0; e < 2; e++)
			for (int c = 0; c < 8; c++)
				for (int p = 1; p < 3; p++)
				begin
					do_reset();
					wr(3'(c), e == 0, swm_pkg::PREQ_NORMAL, 1'b0);
					x = expect_stat(3'(c), swm_pkg::PREQ_NORMAL, e == 1 && c > 4);
					look();
					wr(3'(c), e == 0, 2'(p), 1'b0);
					wr(3'(c) ^ 3'(1 + $urandom % 7), e == 0, 2'(p), 1'b0);
					x = expect_stat(3'(c), 2'(p), e == 1 && c > 4);
					look();
				end
		// arming, silence, pattern return to frame detection and frame wake in normal power, then sleep rearm and restart wake
		do_reset();
		wr(3'h7, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		stw(6'h0d);
		send(3'h0);
		stw(6'h17);
		send(3'h1);
		stw(6'h0d);
		n = irq_seen;
		send(3'h2);
		stw(6'h24);
		chk(32'(irq_seen - n), 32'h1, "wake irq");
		chk(32'(rxd_force_low), 32'h0, "rxd low");
		wr(3'h7, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		stw(6'h24);
		wr(3'h3, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		wr(3'h7, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		stw(6'h0d);
		wr(3'h1, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		// the flag flips on the write edge itself, so look one edge later
		@(posedge pclk);
		chk(32'(selwake_armed_flag), 32'h0, "msb clear");
		wr(3'h5, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		send(3'h2);
		wr(3'h5, 1'b1, swm_pkg::PREQ_SLEEP, 1'b0);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h00001cb7, 32'h000004a5, "sleep rearm");
		n = irq_seen;
		send(3'h2);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h000002f7, 32'h00000035, "restart");
		chk(32'(irq_seen - n), 32'h0, "no irq");
		wr(3'h1, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		wr(3'h1, 1'b1, swm_pkg::PREQ_NORMAL, 1'b1);
		wr(3'h5, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		wr(3'h5, 1'b1, swm_pkg::PREQ_SLEEP, 1'b0);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h000000f7, 32'h000000a5, "rearmed");
		// counter overflow after 32 frame errors
		do_reset();
		wr(3'h7, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		send(3'h4);
		repeat (32) send(3'h3);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h003f1cc0, 32'h00201040, "overflow");
		// config error only counts with a selective wake code
		do_reset();
		wr(3'h3, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		send(3'h5);
		chk(32'(selwake_error_flag), 32'h0, "no sw err");
		// wake-capable code, so the error drops the block into pattern-2 detection
		wr(3'h5, 1'b1, swm_pkg::PREQ_NORMAL, 1'b0);
		send(3'h5);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h00001cc0, 32'h00000cc0, "pattern2");
		send(3'h1);
		apb(1'b0, swm_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h00001c80, 32'h00001000, "pattern wake");
		chk(32'(rxd_force_low), 32'h1, "rxd woken");
		print_verdict();
	end
endmodule
